// file: verilog/acr_pkg.sv
/*
 * Shared constants of the amplifier control register bank: register
 * indices, the byte address width, field positions, reset values and codes.
 * Assumes a 32-bit APB where each register sits in one aligned word.
 */
package acr_pkg;

    // Register indices as printed; the byte address is four times the index.
    localparam logic [15:0] IDX_AMP0_CTRL = 16'hffca;
    localparam logic [15:0] IDX_AMP0_OFS = 16'hffce;
    localparam logic [15:0] IDX_AMP1_CTRL = 16'hffe1;
    localparam logic [15:0] IDX_AMP1_OFS = 16'hffe4;

    // Byte address width that reaches the highest register word.
    localparam int ADDR_W_MIN = 18;

    // Field positions of a control register.
    localparam int GAIN_LSB = 0;
    localparam int SENS_LSB = 2;
    localparam int CAL_BIT = 4;
    localparam int CHAN_LSB = 5;
    localparam int EN_BIT = 7;

    // Field position of the offset register.
    localparam int OFS_BIT = 0;

    // Reset values.
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_OFS = 8'h00;

    // Bits that exist; all others are reserved, read zero, ignore writes.
    localparam logic [7:0] MASK_CTRL0 = 8'hff;
    localparam logic [7:0] MASK_CTRL1 = 8'hf3;
    localparam logic [7:0] MASK_OFS = 8'h01;

    // Gain codes and the gain each one selects.
    localparam logic [4:0] GAIN_X2 = 5'h02;
    localparam logic [4:0] GAIN_X4 = 5'h04;
    localparam logic [4:0] GAIN_X8 = 5'h08;
    localparam logic [4:0] GAIN_X16 = 5'h10;

    // Sensor mux codes on the first amplifier.
    localparam logic [1:0] SENS_INPUT3_A = 2'h0;
    localparam logic [1:0] SENS_VREF = 2'h1;
    localparam logic [1:0] SENS_TEMP = 2'h2;
    localparam logic [1:0] SENS_INPUT3_B = 2'h3;

    // Channel code that picks the shared source on the first amplifier.
    localparam logic [1:0] CHAN_SHARED = 2'h3;

    // Bus slave states.
    typedef enum logic {
        ACR_IDLE,
        ACR_ACK
    } acr_bus_state_t;

endpackage

// file: verilog/acr_amp_regs.sv
/*
 * Holds the control and offset registers of one amplifier.
 * Assumes write strobes come one cycle wide from the bus slave.
 */
`timescale 1ns/1ps
module acr_amp_regs #(
    parameter logic [7:0] CTRL_MASK = 8'hff
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Write strobes and data.
    input wire logic ctrl_we,
    input wire logic ofs_we,
    input wire logic [7:0] wdata,
    // Stored values, reserved bits zero.
    output logic [7:0] ctrl_q,
    output logic [7:0] ofs_q
);

    logic [7:0] ctrl_d;
    logic [7:0] ofs_d;

    // Next values keep only implemented bits of the written byte.
    always_comb begin
        ctrl_d = ctrl_q;
        ofs_d = ofs_q;
        if (ctrl_we) begin
            ctrl_d = wdata & CTRL_MASK;
        end
        if (ofs_we) begin
            ofs_d = wdata & acr_pkg::MASK_OFS;
        end
    end

    // Register the values, cleared by reset.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= acr_pkg::RST_CTRL;
            ofs_q <= acr_pkg::RST_OFS;
        end else begin
            ctrl_q <= ctrl_d;
            ofs_q <= ofs_d;
        end
    end

endmodule

// file: verilog/acr_amp_decode.sv
/*
 * Turns one amplifier's register values into registered control levels.
 * Assumes the register values come from flip-flops on the same clock.
 */
`timescale 1ns/1ps
module acr_amp_decode (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Register values.
    input wire logic [7:0] ctrl,
    input wire logic [7:0] ofs,
    // Amplifier controls.
    output logic enable_q,
    output logic calibrate_q,
    output logic [3:0] chan_oh_q,
    output logic [1:0] gain_code_q,
    output logic [4:0] gain_value_q,
    output logic offset_en_q
);

    logic enable_d;
    logic calibrate_d;
    logic [3:0] chan_oh_d;
    logic [1:0] gain_code_d;
    logic [4:0] gain_value_d;
    logic offset_en_d;

    // Decode each field of the registers.
    always_comb begin
        enable_d = ctrl[acr_pkg::EN_BIT];
        calibrate_d = ctrl[acr_pkg::CAL_BIT];
        chan_oh_d = 4'h1 << ctrl[acr_pkg::CHAN_LSB +: 2];
        gain_code_d = ctrl[acr_pkg::GAIN_LSB +: 2];
        unique case (gain_code_d)
            2'h0: gain_value_d = acr_pkg::GAIN_X2;
            2'h1: gain_value_d = acr_pkg::GAIN_X4;
            2'h2: gain_value_d = acr_pkg::GAIN_X8;
            2'h3: gain_value_d = acr_pkg::GAIN_X16;
        endcase
        offset_en_d = ofs[acr_pkg::OFS_BIT];
    end

    // Register the controls so they leave the block from flip-flops.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            enable_q <= 1'b0;
            calibrate_q <= 1'b0;
            chan_oh_q <= 4'h1;
            gain_code_q <= 2'h0;
            gain_value_q <= acr_pkg::GAIN_X2;
            offset_en_q <= 1'b0;
        end else begin
            enable_q <= enable_d;
            calibrate_q <= calibrate_d;
            chan_oh_q <= chan_oh_d;
            gain_code_q <= gain_code_d;
            gain_value_q <= gain_value_d;
            offset_en_q <= offset_en_d;
        end
    end

endmodule

// file: verilog/acr_regs.sv
/*
 * Register bank for two programmable-gain amplifiers in front of the two
 * converters, reached as an APB slave with zero wait states.
 * Each amplifier has a control word (enable, input channel, calibration,
 * gain) and an offset word; the first control word also steers the sensor
 * mux. Reserved bits read zero and ignore writes, unmapped words answer
 * with pslverr and read zero, and only byte lane 0 carries register bits.
 * Every control output leaves from a flip-flop, one clock after the
 * register that it decodes.
 * Assumes one 100 MHz clock, synchronous active-high reset, and a master
 * that follows the APB setup and access phases.
 */
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps

// Contract
// - Gain codes select two, four, eight, sixteen
// - First amp bits 3:2 steer sensor mux
// - Bit 4 grounds amplifier input for calibration
// - Bits 6:5 choose one of four inputs
// - Bit 7 enables the amplifier
// - Offset register bit 0 enables offset voltage
module acr_regs #(
    parameter int ADDR_W = 18
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave.
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // First amplifier.
    output logic amp0_enable_bit,
    output logic amp0_calibrate_bit,
    output logic [3:0] amp0_channel_oh,
    output logic [1:0] amp0_gain_code,
    output logic [4:0] amp0_gain_value,
    output logic amp0_offset_enable,
    output logic amp0_shared_source,
    // Second amplifier.
    output logic amp1_enable_bit,
    output logic amp1_calibrate_bit,
    output logic [3:0] amp1_channel_oh,
    output logic [1:0] amp1_gain_code,
    output logic [4:0] amp1_gain_value,
    output logic amp1_offset_enable,
    // Sensor mux.
    output logic sens_route_input3,
    output logic sens_route_vref,
    output logic sens_temp_enable
);

    localparam int NUM_AMP = 2;

    // Byte addresses of the four registers. The printed offsets are not all
    // word multiples, so each is kept as an index and the byte address is
    // four times it; the two low address bits must be zero to match.
    localparam logic [ADDR_W-1:0] ADDR_AMP0_CTRL =
        ADDR_W'({acr_pkg::IDX_AMP0_CTRL, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_AMP0_OFS =
        ADDR_W'({acr_pkg::IDX_AMP0_OFS, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_AMP1_CTRL =
        ADDR_W'({acr_pkg::IDX_AMP1_CTRL, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_AMP1_OFS =
        ADDR_W'({acr_pkg::IDX_AMP1_OFS, 2'b00});

    // Refuse an address bus too narrow to reach every register.
    if (ADDR_W < acr_pkg::ADDR_W_MIN) begin : g_addr_check
        $error("acr_regs: ADDR_W too small for the register map");
    end

    // Refuse a map in which two registers would answer in one word.
    if (ADDR_AMP0_CTRL == ADDR_AMP0_OFS || ADDR_AMP0_CTRL == ADDR_AMP1_CTRL ||
        ADDR_AMP0_CTRL == ADDR_AMP1_OFS || ADDR_AMP0_OFS == ADDR_AMP1_CTRL ||
        ADDR_AMP0_OFS == ADDR_AMP1_OFS || ADDR_AMP1_CTRL == ADDR_AMP1_OFS) begin : g_map_check
        $error("acr_regs: two registers share one word");
    end

    // The map and the sensor decode are written for exactly two amplifiers.
    if (NUM_AMP != 2) begin : g_amp_check
        $error("acr_regs: NUM_AMP must be two");
    end

    // Bus slave state, latched read data and error flag.
    acr_pkg::acr_bus_state_t state_q;
    acr_pkg::acr_bus_state_t state_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic err_q;
    logic err_d;

    // Address decode, write strobes and register values.
    logic [NUM_AMP-1:0] ctrl_hit;
    logic [NUM_AMP-1:0] ofs_hit;
    logic any_hit;
    logic access_end;
    logic commit;
    logic [NUM_AMP-1:0] ctrl_we;
    logic [NUM_AMP-1:0] ofs_we;
    logic [7:0] ctrl_val [NUM_AMP];
    logic [7:0] ofs_val [NUM_AMP];
    logic [7:0] rd_byte;

    // Decoded controls of each amplifier.
    logic enable_v [NUM_AMP];
    logic calibrate_v [NUM_AMP];
    logic [3:0] chan_oh_v [NUM_AMP];
    logic [1:0] gain_code_v [NUM_AMP];
    logic [4:0] gain_value_v [NUM_AMP];
    logic offset_en_v [NUM_AMP];

    // Sensor mux and shared-source next and registered values.
    logic sens_input3_d;
    logic sens_vref_d;
    logic sens_temp_d;
    logic shared_d;
    logic sens_input3_q;
    logic sens_vref_q;
    logic sens_temp_q;
    logic shared_q;

    // Address decode of the four words.
    // A full compare, so an alias of a register elsewhere in the space is refused.
    always_comb begin
        ctrl_hit[0] = (paddr == ADDR_AMP0_CTRL);
        ctrl_hit[1] = (paddr == ADDR_AMP1_CTRL);
        ofs_hit[0] = (paddr == ADDR_AMP0_OFS);
        ofs_hit[1] = (paddr == ADDR_AMP1_OFS);
        any_hit = |{ctrl_hit, ofs_hit};
    end

    // A write takes effect only at the edge that ends the access phase.
    // Only the low byte lane carries register bits, so pstrb[0] gates it:
    // a write with that strobe low completes normally but changes nothing,
    // and a refused write raises pslverr and leaves every register alone.
    always_comb begin
        access_end = psel & penable & pready;
        commit = access_end & pwrite & pstrb[0] & ~pslverr;
        ctrl_we = ctrl_hit & {NUM_AMP{commit}};
        ofs_we = ofs_hit & {NUM_AMP{commit}};
    end

    // Read byte of the addressed register; unmapped words read zero.
    // At most one word matches, since the map check keeps the four apart.
    always_comb begin
        rd_byte = 8'h00;
        for (int i = 0; i < NUM_AMP; i++) begin
            if (ctrl_hit[i]) begin
                rd_byte = ctrl_val[i];
            end
            if (ofs_hit[i]) begin
                rd_byte = ofs_val[i];
            end
        end
    end

    // Bus slave: the setup cycle latches read data and the error flag,
    // the following access cycle answers with pready.
    // Latching at setup puts the answer in a flip-flop, and a write that
    // ended just before is already visible in the word read.
    // A master that drops psel before the access phase is let go, so the
    // slave does not hold pready high into a later setup.
    always_comb begin
        state_d = state_q;
        prdata_d = prdata_q;
        err_d = err_q;
        unique case (state_q)
            acr_pkg::ACR_IDLE: begin
                if (psel && !penable) begin
                    state_d = acr_pkg::ACR_ACK;
                    err_d = ~any_hit;
                    prdata_d = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
                end
            end
            acr_pkg::ACR_ACK: begin
                if (psel && penable) begin
                    state_d = acr_pkg::ACR_IDLE;
                end else if (!psel) begin
                    state_d = acr_pkg::ACR_IDLE;
                end
            end
        endcase
    end

    // Bus slave registers.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= acr_pkg::ACR_IDLE;
            prdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            state_q <= state_d;
            prdata_q <= prdata_d;
            err_q <= err_d;
        end
    end

    // Handshake outputs follow the state; read data from a flip-flop.
    // pready is decoded from the state alone, so no combinational path
    // runs from the bus inputs to the handshake outputs.
    always_comb begin
        pready = (state_q == acr_pkg::ACR_ACK);
        pslverr = (state_q == acr_pkg::ACR_ACK) & err_q;
        prdata = prdata_q;
    end

    // One register pair and one decoder per amplifier. The second control
    // word has no sensor field, so its mask clears bits 3:2.
    for (genvar g = 0; g < NUM_AMP; g++) begin : g_amp
        // Register pair with the reserved bits masked on write.
        acr_amp_regs #(
            .CTRL_MASK((g == 0) ? acr_pkg::MASK_CTRL0 : acr_pkg::MASK_CTRL1)
        ) u_regs (
            .sys_clk(sys_clk),
            .rst(rst),
            .ctrl_we(ctrl_we[g]),
            .ofs_we(ofs_we[g]),
            .wdata(pwdata[7:0]),
            .ctrl_q(ctrl_val[g]),
            .ofs_q(ofs_val[g])
        );

        // Decoder that registers this amplifier's fields.
        acr_amp_decode u_decode (
            .sys_clk(sys_clk),
            .rst(rst),
            .ctrl(ctrl_val[g]),
            .ofs(ofs_val[g]),
            .enable_q(enable_v[g]),
            .calibrate_q(calibrate_v[g]),
            .chan_oh_q(chan_oh_v[g]),
            .gain_code_q(gain_code_v[g]),
            .gain_value_q(gain_value_v[g]),
            .offset_en_q(offset_en_v[g])
        );
    end

    // Sensor mux decode from the first control register. The route follows
    // bits 3:2 whether or not the amplifier is enabled, so software may set
    // it before turning the amplifier on.
    always_comb begin
        sens_input3_d = 1'b0;
        sens_vref_d = 1'b0;
        sens_temp_d = 1'b0;
        unique case (ctrl_val[0][acr_pkg::SENS_LSB +: 2])
            acr_pkg::SENS_INPUT3_A: sens_input3_d = 1'b1;
            acr_pkg::SENS_VREF: sens_vref_d = 1'b1;
            acr_pkg::SENS_TEMP: sens_temp_d = 1'b1;
            acr_pkg::SENS_INPUT3_B: sens_input3_d = 1'b1;
        endcase
    end

    // The first amplifier's channel code 11 picks the source it shares with
    // the sensor mux.
    always_comb begin
        shared_d = (ctrl_val[0][acr_pkg::CHAN_LSB +: 2] == acr_pkg::CHAN_SHARED);
    end

    // Sensor mux outputs come from flip-flops, aligned with the decoders.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Route input 3, the decode of an all-zero control word.
            sens_input3_q <= 1'b1;
            sens_vref_q <= 1'b0;
            sens_temp_q <= 1'b0;
            shared_q <= 1'b0;
        end else begin
            sens_input3_q <= sens_input3_d;
            sens_vref_q <= sens_vref_d;
            sens_temp_q <= sens_temp_d;
            shared_q <= shared_d;
        end
    end

    // First amplifier outputs.
    assign amp0_enable_bit = enable_v[0];
    assign amp0_calibrate_bit = calibrate_v[0];
    assign amp0_channel_oh = chan_oh_v[0];
    assign amp0_gain_code = gain_code_v[0];
    assign amp0_gain_value = gain_value_v[0];
    assign amp0_offset_enable = offset_en_v[0];
    assign amp0_shared_source = shared_q;

    // Second amplifier outputs.
    assign amp1_enable_bit = enable_v[1];
    assign amp1_calibrate_bit = calibrate_v[1];
    assign amp1_channel_oh = chan_oh_v[1];
    assign amp1_gain_code = gain_code_v[1];
    assign amp1_gain_value = gain_value_v[1];
    assign amp1_offset_enable = offset_en_v[1];

    // Sensor mux outputs.
    // Exactly one of the three routes is high at any time.
    assign sens_route_input3 = sens_input3_q;
    assign sens_route_vref = sens_vref_q;
    assign sens_temp_enable = sens_temp_q;

endmodule

// file: bench/acr_regs_asserts.sv
/*
 * Concurrent checks on the ports of the amplifier register bank.
 * Assumes an APB master that keeps setup and access phases in order.
 */
`timescale 1ns/1ps
module acr_regs_checker #(
    parameter int ADDR_W = 18
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave.
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Amplifier and sensor controls.
    input wire logic amp0_enable_bit,
    input wire logic [3:0] amp0_channel_oh,
    input wire logic [1:0] amp0_gain_code,
    input wire logic [4:0] amp0_gain_value,
    input wire logic amp0_offset_enable,
    input wire logic [1:0] amp1_gain_code,
    input wire logic sens_route_vref,
    input wire logic sens_temp_enable
);
    localparam logic [17:0] A_C0 = {acr_pkg::IDX_AMP0_CTRL, 2'b00};
    localparam logic [17:0] A_O0 = {acr_pkg::IDX_AMP0_OFS, 2'b00};
    localparam logic [17:0] A_C1 = {acr_pkg::IDX_AMP1_CTRL, 2'b00};
    localparam logic [17:0] A_O1 = {acr_pkg::IDX_AMP1_OFS, 2'b00};
    logic [7:0] wd1_q;
    logic [7:0] wd2_q;
    logic done;
    logic hit;

    // Write data delayed to the cycle in which decoded outputs settle.
    always_ff @(posedge sys_clk) begin
        wd1_q <= pwdata[7:0];
        wd2_q <= wd1_q;
    end

    // Completed transfer and whether its address is one of the four registers.
    assign done = psel && penable && pready;
    assign hit = paddr == A_C0 || paddr == A_O0 || paddr == A_C1 || paddr == A_O1;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_wr(a);
        done && pwrite && pstrb[0] && paddr == a;
    endsequence

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_only_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_unmapped_error: assert property (done && !hit |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_okay: assert property (done && hit |-> !pslverr && prdata[31:8] == 24'h0)
        else $error("mapped access bad response");
    a_gain_table: assert property (amp0_gain_value == (5'h02 << amp0_gain_code))
        else $error("gain value does not match code");
    a_ctrl_decode: assert property (s_wr(A_C0) |=> ##1 amp0_enable_bit == wd2_q[7]
        && amp0_channel_oh == (4'h1 << wd2_q[6:5]) && amp0_gain_code == wd2_q[1:0])
        else $error("control fields not decoded");
    a_sensor_route: assert property (s_wr(A_C0) |=> ##1 sens_temp_enable == (wd2_q[3:2] == 2'h2)
        && sens_route_vref == (wd2_q[3:2] == 2'h1))
        else $error("sensor mux route wrong");
    a_amp1_gain: assert property (s_wr(A_C1) |=> ##1 amp1_gain_code == wd2_q[1:0])
        else $error("second gain code wrong");
    a_offset_follow: assert property (s_wr(A_O0) |=> ##1 amp0_offset_enable == wd2_q[0])
        else $error("offset enable wrong");
    a_strobe_ignored: assert property (done && pwrite && !pstrb[0] |=>
        ($stable(amp0_gain_code) && $stable(amp0_offset_enable) && $stable(amp1_gain_code)) [*2])
        else $error("write without strobe changed state");
endmodule

bind acr_regs acr_regs_checker #(.ADDR_W(ADDR_W)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .amp0_enable_bit(amp0_enable_bit), .amp0_channel_oh(amp0_channel_oh), .amp0_gain_code(amp0_gain_code),
    .amp0_gain_value(amp0_gain_value), .amp0_offset_enable(amp0_offset_enable),
    .amp1_gain_code(amp1_gain_code), .sens_route_vref(sens_route_vref), .sens_temp_enable(sens_temp_enable)
);

// file: bench/acr_regs_test.sv
/*
 * Self-checking bench for the amplifier register bank over APB.
 * Assumes the checker is bound to the bank from its own file.
 */
`timescale 1ns/1ps
module acr_regs_test;
    localparam logic [17:0] A_C0 = {acr_pkg::IDX_AMP0_CTRL, 2'b00};
    localparam logic [17:0] A_O0 = {acr_pkg::IDX_AMP0_OFS, 2'b00};
    localparam logic [17:0] A_C1 = {acr_pkg::IDX_AMP1_CTRL, 2'b00};
    localparam logic [17:0] A_O1 = {acr_pkg::IDX_AMP1_OFS, 2'b00};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [17:0] paddr = 18'h0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [7:0] d;
    logic pready, pslverr, err, a0_en, a0_cal, a0_sh, a0_ofs, a1_en, a1_cal, a1_ofs, s_in3, s_vref, s_temp;
    logic [3:0] a0_ch, a1_ch;
    logic [1:0] a0_gc, a1_gc;
    logic [4:0] a0_gv, a1_gv;
    int failures = 0;
    int checks = 0;

    acr_regs #(.ADDR_W(18)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .amp0_enable_bit(a0_en), .amp0_calibrate_bit(a0_cal), .amp0_channel_oh(a0_ch),
        .amp0_gain_code(a0_gc), .amp0_gain_value(a0_gv), .amp0_offset_enable(a0_ofs),
        .amp0_shared_source(a0_sh), .amp1_enable_bit(a1_en), .amp1_calibrate_bit(a1_cal),
        .amp1_channel_oh(a1_ch), .amp1_gain_code(a1_gc), .amp1_gain_value(a1_gv),
        .amp1_offset_enable(a1_ofs), .sens_route_input3(s_in3), .sens_route_vref(s_vref),
        .sens_temp_enable(s_temp)
    );

    // Free-running 100 MHz clock.
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; pready and the answer are taken at one rising edge, then the request is released.
    task automatic xfer(input logic [17:0] a, input logic w, input logic [31:0] wd, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= s;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) begin
            @(posedge sys_clk);
            n++;
        end
        chk("wait states", 32'h0, n);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [17:0] a, input logic [31:0] wd);
        xfer(a, 1'b1, wd, 4'hf);
    endtask

    task automatic rdchk(input string name, input logic [17:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0, 4'h0);
        chk(name, exp, rd);
        chk("response", 32'h0, err);
    endtask

    // Lets the register write and the decoded outputs land.
    task automatic settle();
        repeat (2) @(negedge sys_clk);
    endtask

    // Reset levels of the outputs and the four registers.
    task automatic reset_checks();
        settle();
        chk("reset levels", {2'b00, 4'h1, 5'h02, 5'h00, 4'h1, 5'h02, 3'b100, 4'h0},
            {a0_en, a0_cal, a0_ch, a0_gv, a0_ofs, a0_sh, a1_en, a1_cal, a1_ofs, a1_ch, a1_gv,
             s_in3, s_vref, s_temp, a0_gc, a1_gc});
        rdchk("c0 reset", A_C0, 32'h0);
        rdchk("o0 reset", A_O0, 32'h0);
        rdchk("c1 reset", A_C1, 32'h0);
        rdchk("o1 reset", A_O1, 32'h0);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (3000) @(posedge sys_clk);
        failures++;
        complete_run();
    end

    // Main sequence: every code of every field, reserved bits, refusals, mid-run reset.
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        reset_checks();
        for (int i = 0; i < 4; i++) begin
            d = {i[0], i[1:0], i[1], i[1:0], i[1:0]};
            wr(A_C0, 32'hffffff00 | d);
            wr(A_C1, 32'hffffff00 | d);
            settle();
            chk("gain0", 32'h2 << i, a0_gv);
            chk("gain1", 32'h2 << i, a1_gv);
            chk("mux", (i == 1 || i == 2) ? 32'h1 << i : 32'h1, {s_temp, s_vref, s_in3});
            chk("cal", {2{i[1]}}, {a1_cal, a0_cal});
            chk("chan0", 32'h1 << i, a0_ch);
            chk("chan1", 32'h1 << i, a1_ch);
            chk("shared", i == 3, a0_sh);
            chk("enable", {2{i[0]}}, {a1_en, a0_en});
            chk("codes", {i[1:0], i[1:0]}, {a1_gc, a0_gc});
            rdchk("c0 read", A_C0, d);
            rdchk("c1 read", A_C1, d & 8'hf3);
        end
        wr(A_O0, 32'hffffffff);
        wr(A_O1, 32'hfffffffe);
        settle();
        chk("offset a", 32'h1, {a1_ofs, a0_ofs});
        rdchk("o0 read", A_O0, 32'h1);
        rdchk("o1 read", A_O1, 32'h0);
        wr(A_O0, 32'h0);
        wr(A_O1, 32'h1);
        settle();
        chk("offset b", 32'h2, {a1_ofs, a0_ofs});
        xfer(A_C0, 1'b1, 32'h55, 4'he);
        rdchk("no strobe", A_C0, 32'hff);
        xfer(18'h3ff2c, 1'b1, 32'h0, 4'hf);
        chk("unmapped wr", 32'h1, err);
        xfer(18'h00010, 1'b0, 32'h0, 4'h0);
        chk("unmapped rd", 32'h0, rd);
        chk("unmapped rd err", 32'h1, err);
        rdchk("c0 kept", A_C0, 32'hff);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        reset_checks();
        complete_run();
    end
endmodule
